// *** hw/cbt_bit_timing.sv ***
// bit timing, resynchronisation and sample logic for the can receive line
`timescale 1ns/1ps
`default_nettype none
`include "cbt_defs.svh"
module cbt_bit_timing #(
  parameter int unsigned TQ_DIV = `CBT_TQ_CYC
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_wr_en,
  input wire logic [3:0] i_wr_addr,
  input wire logic [`CBT_REG_W-1:0] i_wr_data,
  input wire logic i_rx,
  output logic [`CBT_REG_W-1:0] o_bit_timing_control,
  output logic o_bit_valid,
  output logic o_bit_value,
  output logic o_in_frame
);
  // ==========================================================
  // configuration register
  logic [`CBT_REG_W-1:0] cfg_ff;
  logic [`CBT_REG_W-1:0] nxt_cfg;
  logic [3:0] phase_seg_two_len;
  logic [3:0] phase_seg_one_len;
  logic [3:0] edge_jump_extra;

  always_comb begin
    nxt_cfg = cfg_ff;
    if (i_wr_en && i_wr_addr == `CBT_REG_ADDR) begin
      nxt_cfg = i_wr_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cfg_ff <= `CBT_REG_RESET;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  assign phase_seg_two_len = cfg_ff[`CBT_PS2_MSB:`CBT_PS2_LSB];
  assign phase_seg_one_len = cfg_ff[`CBT_PS1_MSB:`CBT_PS1_LSB];
  assign edge_jump_extra = cfg_ff[`CBT_EJ_MSB:`CBT_EJ_LSB];
  assign o_bit_timing_control = cfg_ff;

  // ==========================================================
  // quantum enable
  logic tq;
  logic restart;

  cbt_quantum_gen #(
    .DIV(TQ_DIV)
  ) cbt_quantum_gen_inst (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_restart(restart),
    .o_tq(tq)
  );

  // ==========================================================
  // bit segment sequencer
  cbt_pkg::cbt_seg_e seg_ff;
  cbt_pkg::cbt_seg_e nxt_seg;
  logic [5:0] cnt_ff;
  logic [5:0] nxt_cnt;
  logic [5:0] len_ff;
  logic [5:0] nxt_len;
  logic rx_ff;
  logic nxt_rx;
  logic [3:0] idle_ff;
  logic [3:0] nxt_idle;
  logic bitv_ff;
  logic nxt_bitv;
  logic bitval_ff;
  logic nxt_bitval;
  logic edge_det;
  logic fall;
  logic [5:0] sjw;
  logic [5:0] seg1_nom;
  logic [5:0] seg1_rest;
  logic [5:0] seg2_nom;
  logic [5:0] elapsed;

  assign edge_det = (i_rx != rx_ff);
  assign fall = rx_ff & ~i_rx;
  assign sjw = fall ? (6'h01 + {2'h0, edge_jump_extra}) : 6'h01;
  assign seg1_nom = 6'h01 + {2'h0, phase_seg_one_len};
  // sync quantum is the leading quantum of seg1, so only the rest is counted after it
  assign seg1_rest = {2'h0, phase_seg_one_len};
  assign seg2_nom = {2'h0, phase_seg_two_len};
  assign elapsed = cnt_ff;
  assign restart = (seg_ff == cbt_pkg::CBT_IDLE) && fall;

  always_comb begin
    nxt_seg = seg_ff;
    nxt_cnt = cnt_ff;
    nxt_len = len_ff;
    nxt_rx = i_rx;
    nxt_idle = idle_ff;
    nxt_bitv = 1'b0;
    nxt_bitval = bitval_ff;
    case (seg_ff)
      cbt_pkg::CBT_IDLE: begin
        if (fall) begin
          nxt_seg = cbt_pkg::CBT_SYNC;
          nxt_cnt = 6'h00;
          nxt_idle = 4'h0;
        end
      end
      cbt_pkg::CBT_SYNC: begin
        if (tq) begin
          nxt_seg = cbt_pkg::CBT_SEG1;
          nxt_cnt = 6'h00;
          nxt_len = seg1_rest;
        end
      end
      cbt_pkg::CBT_SEG1: begin
        if (edge_det) begin
          // late edge: stretch seg1 by up to the jump width
          nxt_len = len_ff + ((elapsed < sjw) ? elapsed : sjw);
        end
        if (tq || len_ff == 6'h00) begin
          if (cnt_ff + 6'h01 >= nxt_len) begin
            nxt_bitv = 1'b1;
            nxt_bitval = i_rx;
            nxt_cnt = 6'h00;
            nxt_len = seg2_nom;
            nxt_seg = cbt_pkg::CBT_SEG2;
            if (i_rx) begin
              nxt_idle = (idle_ff == `CBT_IDLE_BITS) ? idle_ff : idle_ff + 4'h1;
            end else begin
              nxt_idle = 4'h0;
            end
          end else begin
            nxt_cnt = cnt_ff + 6'h01;
          end
        end
      end
      cbt_pkg::CBT_SEG2: begin
        if (edge_det) begin
          // early edge: cut seg2 short by the jump width, or start the next bit now if no more than that is left
          if (len_ff - cnt_ff <= sjw) begin
            nxt_seg = cbt_pkg::CBT_SEG1;
            nxt_cnt = 6'h00;
            nxt_len = seg1_nom;
          end else begin
            nxt_len = len_ff - sjw;
          end
        end else if (tq || len_ff == 6'h00) begin
          if (cnt_ff + 6'h01 >= len_ff) begin
            nxt_seg = (idle_ff == `CBT_IDLE_BITS) ? cbt_pkg::CBT_IDLE : cbt_pkg::CBT_SYNC;
            nxt_cnt = 6'h00;
          end else begin
            nxt_cnt = cnt_ff + 6'h01;
          end
        end
      end
      default: begin
        nxt_seg = cbt_pkg::CBT_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      seg_ff <= cbt_pkg::CBT_IDLE;
      cnt_ff <= 6'h00;
      len_ff <= 6'h00;
      rx_ff <= 1'b1;
      idle_ff <= 4'h0;
      bitv_ff <= 1'b0;
      bitval_ff <= 1'b1;
    end else begin
      seg_ff <= nxt_seg;
      cnt_ff <= nxt_cnt;
      len_ff <= nxt_len;
      rx_ff <= nxt_rx;
      idle_ff <= nxt_idle;
      bitv_ff <= nxt_bitv;
      bitval_ff <= nxt_bitval;
    end
  end

  assign o_bit_valid = bitv_ff;
  assign o_bit_value = bitval_ff;
  assign o_in_frame = (seg_ff != cbt_pkg::CBT_IDLE);
endmodule
`default_nettype wire

// *** hw/cbt_quantum_gen.sv ***
// time quantum enable divider driven by the trimmed oscillator clock
`timescale 1ns/1ps
`default_nettype none
`include "cbt_defs.svh"
module cbt_quantum_gen #(
  parameter int unsigned DIV = `CBT_TQ_CYC
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_restart,
  output logic o_tq
);
  localparam int unsigned CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic tq_ff;
  logic nxt_tq;

  always_comb begin
    nxt_tq = 1'b0;
    nxt_cnt = cnt_ff + CW'(1);
    if (i_restart) begin
      nxt_cnt = '0;
    end else if (cnt_ff == LAST) begin
      nxt_cnt = '0;
      nxt_tq = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cnt_ff <= '0;
      tq_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tq_ff <= nxt_tq;
    end
  end

  assign o_tq = tq_ff;
endmodule
`default_nettype wire

// *** inc/cbt_defs.svh ***
// constants for the can bit timing and resynchronisation block
`ifndef CBT_DEFS_SVH
`define CBT_DEFS_SVH
`define CBT_REG_ADDR 4'ha
`define CBT_REG_W 12
`define CBT_REG_RESET 12'h000
`define CBT_PS2_MSB 11
`define CBT_PS2_LSB 8
`define CBT_PS1_MSB 7
`define CBT_PS1_LSB 4
`define CBT_EJ_MSB 3
`define CBT_EJ_LSB 0
`define CBT_TQ_NS 1000
`define CBT_CLK_NS 10
`define CBT_TQ_CYC ((`CBT_TQ_NS + `CBT_CLK_NS - 1) / `CBT_CLK_NS)
`define CBT_SYNC_TQ 5'h01
`define CBT_IDLE_BITS 4'hb
`endif

// *** inc/cbt_pkg.sv ***
// types for the can bit timing and resynchronisation block
package cbt_pkg;
  typedef enum logic [1:0] {
    CBT_IDLE = 2'b00,
    CBT_SYNC = 2'b01,
    CBT_SEG1 = 2'b10,
    CBT_SEG2 = 2'b11
  } cbt_seg_e;
endpackage

// *** sim/cbt_bit_timing_checker.sv ***
// port assertions for the bit timing block
`timescale 1ns/1ps
`default_nettype none
module cbt_bit_timing_checker #(parameter int unsigned TQ_DIV = 100) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_wr_en,
  input wire logic [3:0] i_wr_addr,
  input wire logic [11:0] i_wr_data,
  input wire logic i_rx,
  input wire logic [11:0] o_bit_timing_control,
  input wire logic o_bit_valid,
  input wire logic o_bit_value,
  input wire logic o_in_frame
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  wire logic hit = i_wr_en && i_wr_addr == 4'ha;
  property p_wr; hit |=> o_bit_timing_control == $past(i_wr_data); endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  property p_keep; !hit |=> $stable(o_bit_timing_control); endproperty
  a_keep: assert property (p_keep) else $error("config moved");
  property p_rst; $fell(i_srst) |-> o_bit_timing_control == 12'h000 && !o_in_frame; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_sof; !o_in_frame && $fell(i_rx) |=> o_in_frame; endproperty
  a_sof: assert property (p_sof) else $error("no frame start");
  property p_gap; o_bit_valid |=> !o_bit_valid [*3]; endproperty
  a_gap: assert property (p_gap) else $error("bits too close");
  property p_quiet; $rose(o_in_frame) |-> !o_bit_valid [*4]; endproperty
  a_quiet: assert property (p_quiet) else $error("early sample");
  property p_hold; $changed(o_bit_value) |-> o_bit_valid || $past(i_srst); endproperty
  a_hold: assert property (p_hold) else $error("value moved");
  property p_in; o_bit_valid |-> o_in_frame || $past(o_in_frame); endproperty
  a_in: assert property (p_in) else $error("sample outside frame");
  c_bit: cover property (o_bit_valid && !o_bit_value);
  c_sof: cover property ($rose(o_in_frame));
  c_end: cover property ($fell(o_in_frame));
endmodule
`default_nettype wire

// *** sim/cbt_bus_node.sv ***
// bus node model sending frames on the receive line
`timescale 1ns/1ps
`default_nettype none
module cbt_bus_node (
  input wire logic i_clk,
  output logic o_rx
);
  // recessive level between frames
  initial o_rx = 1'b1;
  task automatic send(input logic [7:0] bits, input int bit_cyc);
    for (int i = 7; i >= 0; i--) begin
      o_rx = bits[i];
      repeat (bit_cyc) @(negedge i_clk);
    end
    o_rx = 1'b1;
  endtask
endmodule
`default_nettype wire

// *** sim/tb_can_bit_timing_sync.sv ***
// testbench for the bit timing block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module tb_can_bit_timing_sync;
  typedef struct {logic [11:0] cfg; logic [7:0] bits; int slow;} cbt_row_s;
  cbt_row_s rows[4] = '{'{12'h421, 8'h5a, 0}, '{12'h512, 8'h4b, 0}, '{12'h633, 8'h55, 1}, '{12'h633, 8'h55, -1}};
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_wr_en = 1'b0;
  logic [3:0] i_wr_addr = 4'h0;
  logic [11:0] i_wr_data = 12'h000;
  wire logic i_rx;
  logic [11:0] o_bit_timing_control;
  logic o_bit_valid;
  logic o_bit_value;
  logic o_in_frame;
  int mismatches = 0;
  int checks_done = 0;
  int n;
  always #5 i_clk = ~i_clk;
  cbt_bit_timing #(.TQ_DIV(4)) cbt_bit_timing_inst (.i_clk(i_clk), .i_srst(i_srst), .i_wr_en(i_wr_en),
    .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data), .i_rx(i_rx), .o_bit_timing_control(o_bit_timing_control),
    .o_bit_valid(o_bit_valid), .o_bit_value(o_bit_value), .o_in_frame(o_in_frame));
  cbt_bus_node cbt_bus_node_inst (.i_clk(i_clk), .o_rx(i_rx));
  task automatic wr(input logic [3:0] a, input logic [11:0] d);
    i_wr_en = 1'b1;
    i_wr_addr = a;
    i_wr_data = d;
    @(negedge i_clk);
    i_wr_en = 1'b0;
    @(negedge i_clk);
  endtask
  task automatic wait_valid(output int c);
    c = 0;
    do begin
      @(negedge i_clk);
      c++;
    end while (o_bit_valid !== 1'b1 && c < 200);
  endtask
  task automatic idle();
    for (int k = 0; k < 600 && o_in_frame === 1'b1; k++) @(negedge i_clk);
    `CHK("idle", 1'b0, o_in_frame)
  endtask
  task automatic frame(input logic [7:0] b, input int bc);
    logic [7:0] got;
    int c;
    fork
      cbt_bus_node_inst.send(b, bc);
      for (int i = 7; i >= 0; i--) begin
        wait_valid(c);
        got[i] = o_bit_value;
      end
    join
    `CHK("bits", b, got)
    idle();
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ====
  // sequence
  initial begin
    repeat (5) @(negedge i_clk);
    i_srst = 1'b0;
    `CHK("rst", 14'h0001, {o_bit_timing_control, o_in_frame, o_bit_value})
    foreach (rows[r]) begin
      wr(4'ha, rows[r].cfg);
      `CHK("cfg", rows[r].cfg, o_bit_timing_control)
      frame(rows[r].bits, 4 * (1 + rows[r].cfg[7:4] + rows[r].cfg[11:8] + rows[r].slow));
    end
    wr(4'hb, 12'hfff);
    wr(4'h0, 12'hfff);
    `CHK("cfg", 12'h633, o_bit_timing_control)
    wr(4'ha, 12'h421);
    fork
      cbt_bus_node_inst.send(8'h5a, 28);
      begin
        @(negedge i_clk);
        `CHK("frm", 1'b1, o_in_frame)
        wait_valid(n);
        `CHK("lat", 1'b1, n inside {[12:14]})
      end
    join
    idle();
    fork
      cbt_bus_node_inst.send(8'h5a, 28);
      begin
        repeat (40) @(negedge i_clk);
        i_srst = 1'b1;
        @(negedge i_clk);
        i_srst = 1'b0;
        `CHK("mid", 14'h0001, {o_bit_timing_control, o_in_frame, o_bit_value})
      end
    join
    idle();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    conclude();
  end
endmodule
bind cbt_bit_timing cbt_bit_timing_checker #(.TQ_DIV(TQ_DIV)) cbt_bit_timing_checker_inst (.i_clk(i_clk),
  .i_srst(i_srst), .i_wr_en(i_wr_en), .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data), .i_rx(i_rx),
  .o_bit_timing_control(o_bit_timing_control), .o_bit_valid(o_bit_valid), .o_bit_value(o_bit_value),
  .o_in_frame(o_in_frame));
`default_nettype wire
